// *** src/fsra_core.sv ***
// Top of the flash suspend/resume admission logic.
`timescale 1ns/1ps
module fsra_core
(
	input  wire logic       sys_clk,        // System clock, 10 MHz.
	input  wire logic       rst_n,          // Asynchronous reset, active low.
	input  wire logic       cmd_valid,      // One-cycle pulse: a decoded instruction.
	input  wire logic [3:0] cmd_class,      // Instruction class, fsra_cmd_t code.
	input  wire logic       cmd_same_sect,  // Target is the suspended sector.
	input  wire logic       op_done,        // Pulse: running program or erase finished.
	output logic            cmd_accept,     // One-cycle pulse: instruction admitted.
	output logic            cmd_reject,     // One-cycle pulse: instruction refused.
	output logic            data_unsure,    // With accept: read data may be invalid.
	output logic            busy_progress_bit, // Status progress bit.
	output logic            ctrl_ready,     // Flag status controller-ready bit.
	output logic            suspend_flag,   // Flag status suspend bit.
	output logic [5:0]      dev_state       // Current state, one-hot code.
);
	fsra_pkg::fsra_state_t state_r;
	fsra_pkg::fsra_state_t state_nxt;
	fsra_pkg::fsra_state_t outer_r;     // Erase suspension held beneath a nested program.
	logic                  nested_r;
	logic                  ok;
	logic                  lat_start;
	logic                  lat_done;
	logic [7:0]            lat_val;
	fsra_pkg::fsra_cmd_t   cmd;

	assign cmd = fsra_pkg::fsra_cmd_t'(cmd_class);

	// True in any of the three suspended states.
	function automatic logic is_susp(fsra_pkg::fsra_state_t st);
		is_susp = (st == fsra_pkg::FSRA_ST_SUBSECT_SUSP) || (st == fsra_pkg::FSRA_ST_PROGRAM_SUSP)
			|| (st == fsra_pkg::FSRA_ST_ERASE_SUSP);
	endfunction

	// True while a program or erase cycle is running.
	function automatic logic is_active(fsra_pkg::fsra_state_t st);
		is_active = (st == fsra_pkg::FSRA_ST_PROGRAM) || (st == fsra_pkg::FSRA_ST_ERASE);
	endfunction

	// Admission decision for one instruction class in one state.
	function automatic logic admit(fsra_pkg::fsra_state_t st, fsra_pkg::fsra_cmd_t c, logic same);
		logic susp;
		logic idle;
		susp = is_susp(st);
		idle = (st == fsra_pkg::FSRA_ST_STANDBY);
		case (c)
			fsra_pkg::FSRA_CMD_STATUS_READ:  admit = 1'b1;
			fsra_pkg::FSRA_CMD_ARRAY_READ:   admit = idle || susp;
			fsra_pkg::FSRA_CMD_PAGE_PROGRAM: admit = idle
				|| (st == fsra_pkg::FSRA_ST_ERASE_SUSP && !same);
			fsra_pkg::FSRA_CMD_SECTOR_WIPE:  admit = idle;
			fsra_pkg::FSRA_CMD_SUBSECT_WIPE: admit = idle;
			fsra_pkg::FSRA_CMD_STANDBY_WR:   admit = idle;
			fsra_pkg::FSRA_CMD_VOLATILE_WR:  admit = idle || susp;
			fsra_pkg::FSRA_CMD_SUSPEND:      admit = is_active(st);
			fsra_pkg::FSRA_CMD_RESUME:       admit = susp;
			default:                         admit = 1'b0;
		endcase
	endfunction

	assign ok = cmd_valid && admit(state_r, cmd, cmd_same_sect);

	// Erase in progress is tracked by which kind, so suspend lands in the right state.
	logic sub_r;

	// Next state: an accepted command acts first; a finished cycle is honoured otherwise.
	// A status read may coincide with completion, so completion must not be lost then.
	always_comb
	begin
		state_nxt = state_r;
		lat_start = 1'b0;
		lat_val   = fsra_pkg::SUSP_LAT_PRG_CYC;
		if (ok)
		begin
			case (cmd)
				fsra_pkg::FSRA_CMD_PAGE_PROGRAM: state_nxt = fsra_pkg::FSRA_ST_PROGRAM;
				fsra_pkg::FSRA_CMD_SECTOR_WIPE:  state_nxt = fsra_pkg::FSRA_ST_ERASE;
				fsra_pkg::FSRA_CMD_SUBSECT_WIPE: state_nxt = fsra_pkg::FSRA_ST_ERASE;
				fsra_pkg::FSRA_CMD_SUSPEND:
				begin
					lat_start = 1'b1;
					if (state_r == fsra_pkg::FSRA_ST_PROGRAM)
						state_nxt = fsra_pkg::FSRA_ST_PROGRAM_SUSP;
					else
					begin
						lat_val   = fsra_pkg::SUSP_LAT_ERS_CYC;
						state_nxt = sub_r ? fsra_pkg::FSRA_ST_SUBSECT_SUSP : fsra_pkg::FSRA_ST_ERASE_SUSP;
					end
				end
				fsra_pkg::FSRA_CMD_RESUME:
					state_nxt = (state_r == fsra_pkg::FSRA_ST_PROGRAM_SUSP) ? fsra_pkg::FSRA_ST_PROGRAM
						: fsra_pkg::FSRA_ST_ERASE;
				default:
				begin
					if (op_done && is_active(state_r))
						state_nxt = nested_r ? outer_r : fsra_pkg::FSRA_ST_STANDBY;
				end
			endcase
		end
		else if (op_done && is_active(state_r))
			state_nxt = nested_r ? outer_r : fsra_pkg::FSRA_ST_STANDBY;
	end

	// Single state register holding the one current device state.

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= fsra_pkg::FSRA_ST_STANDBY;
		else
			state_r <= state_nxt;
	end

	// Remembers whether the running erase is a subsector erase.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sub_r <= 1'b0;
		else if (ok && cmd == fsra_pkg::FSRA_CMD_SECTOR_WIPE)
			sub_r <= 1'b0;
		else if (ok && cmd == fsra_pkg::FSRA_CMD_SUBSECT_WIPE)
			sub_r <= 1'b1;
	end

	// A program started from erase suspension nests one level beneath it.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nested_r <= 1'b0;
			outer_r  <= fsra_pkg::FSRA_ST_STANDBY;
		end
		else if (ok && cmd == fsra_pkg::FSRA_CMD_PAGE_PROGRAM && state_r == fsra_pkg::FSRA_ST_ERASE_SUSP)
		begin
			nested_r <= 1'b1;
			outer_r  <= fsra_pkg::FSRA_ST_ERASE_SUSP;
		end
		else if (state_r == fsra_pkg::FSRA_ST_ERASE_SUSP && ok && cmd == fsra_pkg::FSRA_CMD_RESUME)
			nested_r <= 1'b0;
		else if (op_done && state_r == fsra_pkg::FSRA_ST_PROGRAM && nested_r)
			nested_r <= 1'b0;
	end

	// Counts the suspend latency; the erase figure applies to both erase kinds.
	fsra_latency u_lat
	(
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.start    (lat_start),
		.load_val (lat_val),
		.done     (lat_done)
	);

	// Suspend flag rises on the suspend and falls on a resume or completion that leaves no erase suspended.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			suspend_flag <= 1'b0;
		else if (lat_start)
			suspend_flag <= 1'b1;
		else if (ok && cmd == fsra_pkg::FSRA_CMD_RESUME)
			suspend_flag <= nested_r && state_r == fsra_pkg::FSRA_ST_PROGRAM_SUSP;
		else if (state_nxt == fsra_pkg::FSRA_ST_STANDBY)
			suspend_flag <= 1'b0;
	end

	// Busy bits: set by a start or a resume, cleared by latency expiry or completion.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_progress_bit <= 1'b0;
			ctrl_ready        <= 1'b1;
		end
		else if (is_active(state_nxt))
		begin
			busy_progress_bit <= 1'b1;
			ctrl_ready        <= 1'b0;
		end
		else if (lat_done || state_nxt == fsra_pkg::FSRA_ST_STANDBY
			|| (state_r == fsra_pkg::FSRA_ST_PROGRAM && state_nxt == fsra_pkg::FSRA_ST_ERASE_SUSP))
		begin
			busy_progress_bit <= 1'b0;
			ctrl_ready        <= 1'b1;
		end
	end

	// Answer pulses: exactly one of them follows every instruction.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_accept  <= 1'b0;
			cmd_reject  <= 1'b0;
		end
		else
		begin
			cmd_accept  <= ok;
			cmd_reject  <= cmd_valid && !ok;
		end
	end

	// A same-sector read under a suspended erase is admitted but its data are not trustworthy.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			data_unsure <= 1'b0;
		else
			data_unsure <= ok && cmd == fsra_pkg::FSRA_CMD_ARRAY_READ && cmd_same_sect
				&& is_susp(state_r) && state_r != fsra_pkg::FSRA_ST_PROGRAM_SUSP;
	end

	assign dev_state = state_r;
endmodule

// *** src/fsra_pkg.sv ***
// Constants, command classes and states of the flash suspend/resume admission block.
package fsra_pkg;

	typedef enum logic [3:0]
	{
		FSRA_CMD_NONE         = 4'h0,
		FSRA_CMD_STATUS_READ  = 4'h1,
		FSRA_CMD_ARRAY_READ   = 4'h2,
		FSRA_CMD_PAGE_PROGRAM = 4'h3,
		FSRA_CMD_SECTOR_WIPE  = 4'h4,
		FSRA_CMD_SUBSECT_WIPE = 4'h5,
		FSRA_CMD_STANDBY_WR   = 4'h6,
		FSRA_CMD_VOLATILE_WR  = 4'h7,
		FSRA_CMD_SUSPEND      = 4'h8,
		FSRA_CMD_RESUME       = 4'h9
	} fsra_cmd_t;

	typedef enum logic [5:0]
	{
		FSRA_ST_STANDBY      = 6'h01,
		FSRA_ST_PROGRAM      = 6'h02,
		FSRA_ST_ERASE        = 6'h04,
		FSRA_ST_SUBSECT_SUSP = 6'h08,
		FSRA_ST_PROGRAM_SUSP = 6'h10,
		FSRA_ST_ERASE_SUSP   = 6'h20
	} fsra_state_t;

	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned SUSP_LAT_PRG_US = 7;
	localparam int unsigned SUSP_LAT_ERS_US = 15;
	localparam logic [7:0] SUSP_LAT_PRG_CYC = 8'((SUSP_LAT_PRG_US * CLK_HZ + 999_999) / 1_000_000);
	localparam logic [7:0] SUSP_LAT_ERS_CYC = 8'((SUSP_LAT_ERS_US * CLK_HZ + 999_999) / 1_000_000);
	localparam logic [7:0] CNT_ZERO         = 8'h00;
	localparam logic [7:0] CNT_ONE          = 8'h01;

endpackage

// *** src/fsra_latency.sv ***
// Suspend latency counter that reports when a suspend has taken effect.
`timescale 1ns/1ps
module fsra_latency
(
	input  wire logic       sys_clk,  // System clock.
	input  wire logic       rst_n,    // Asynchronous reset, active low.
	input  wire logic       start,    // Pulse that loads a new count.
	input  wire logic [7:0] load_val, // Cycles to wait.
	output logic            done      // One-cycle pulse at expiry.
);
	logic [7:0] cnt_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= fsra_pkg::CNT_ZERO;
		else if (start)
			cnt_r <= load_val;
		else if (cnt_r != fsra_pkg::CNT_ZERO)
			cnt_r <= cnt_r - fsra_pkg::CNT_ONE;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			done <= 1'b0;
		else
			done <= !start && (cnt_r == fsra_pkg::CNT_ONE);
	end
endmodule

// *** testbench/fsra_host.sv ***
// Behavioural host that issues decoded flash instructions.
`timescale 1ns/1ps
module fsra_host
(
	input  wire logic       sys_clk,      // Clock.
	output logic            cmd_valid,    // Instruction strobe.
	output logic [3:0]      cmd_class,    // Instruction class.
	output logic            cmd_same_sect // Target is the suspended sector.
);
	initial
	begin
		cmd_valid = 1'h0;
		cmd_class = 4'h0;
		cmd_same_sect = 1'h0;
	end
	// Released lines show the inverse so a stale value is never trusted.
	task automatic send(input logic [3:0] c, input logic s, input int gap);
		repeat (gap + 1) @(posedge sys_clk);
		#1 cmd_valid = 1'h1;
		cmd_class = c;
		cmd_same_sect = s;
		@(posedge sys_clk);
		#1 cmd_valid = 1'h0;
		cmd_class = ~c;
		cmd_same_sect = ~s;
	endtask
	task automatic resume();
		send(4'h9, 1'h0, 0);
	endtask
endmodule

// *** testbench/fsra_monitor.sv ***
// Concurrent checks on the admission block ports.
`timescale 1ns/1ps
module fsra_monitor
(
	input wire logic       sys_clk,           // Clock.
	input wire logic       rst_n,             // Reset, active low.
	input wire logic       cmd_valid,         // Strobe.
	input wire logic [3:0] cmd_class,         // Class.
	input wire logic       cmd_same_sect,     // Same sector.
	input wire logic       op_done,           // Cycle end.
	input wire logic       cmd_accept,        // Admitted.
	input wire logic       cmd_reject,        // Refused.
	input wire logic       data_unsure,       // Data may be bad.
	input wire logic       busy_progress_bit, // Busy.
	input wire logic       ctrl_ready,        // Ready.
	input wire logic       suspend_flag,      // Suspended.
	input wire logic [5:0] dev_state          // State.
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	one_answer_a: assert property (cmd_valid |=> cmd_accept != cmd_reject)
		else $error("no single answer");
	status_read_a: assert property (cmd_valid && cmd_class == 4'h1 |=> cmd_accept)
		else $error("status read refused");
	busy_read_a: assert property (cmd_valid && cmd_class == 4'h2 && dev_state inside {6'h02, 6'h04} |=> cmd_reject)
		else $error("read during busy admitted");
	program_block_a: assert property (cmd_valid && cmd_class == 4'h3 && (dev_state inside {6'h08, 6'h10}
		|| dev_state == 6'h20 && cmd_same_sect) |=> cmd_reject)
		else $error("page program admitted");
	wipe_standby_a: assert property (cmd_valid && cmd_class inside {4'h4, 4'h5, 4'h6} && dev_state != 6'h01
		|=> cmd_reject && $stable(dev_state))
		else $error("standby-only command admitted");
	suspend_gate_a: assert property (cmd_valid && cmd_class == 4'h8 && !(dev_state inside {6'h02, 6'h04})
		|=> cmd_reject)
		else $error("suspend admitted");
	resume_ignore_a: assert property (cmd_valid && cmd_class == 4'h9 && dev_state inside {6'h01, 6'h02, 6'h04}
		|=> cmd_reject && $stable(dev_state) && $stable(busy_progress_bit))
		else $error("stray resume acted");
	resume_busy_a: assert property (cmd_valid && cmd_class == 4'h9 ##1 cmd_accept
		|-> busy_progress_bit && !ctrl_ready)
		else $error("resume left idle");
	suspend_flag_a: assert property (cmd_valid && cmd_class == 4'h8 ##1 cmd_accept
		|-> suspend_flag && busy_progress_bit ##1 busy_progress_bit)
		else $error("suspend flag late");
	unsure_accept_a: assert property (data_unsure |-> cmd_accept)
		else $error("unsure without accept");
	cover property (dev_state == 6'h20 ##[1:400] dev_state == 6'h10);
	cover property (data_unsure);
	cover property (dev_state == 6'h08);
endmodule
bind fsra_core fsra_monitor u_fsra_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
	.cmd_class(cmd_class), .cmd_same_sect(cmd_same_sect), .op_done(op_done), .cmd_accept(cmd_accept),
	.cmd_reject(cmd_reject), .data_unsure(data_unsure), .busy_progress_bit(busy_progress_bit),
	.ctrl_ready(ctrl_ready), .suspend_flag(suspend_flag), .dev_state(dev_state));

// *** testbench/fsra_core_tb.sv ***
// Self-checking bench for the admission block.
`timescale 1ns/1ps
module fsra_core_tb;
	logic sys_clk, rst_n, op_done, cmd_valid, cmd_same_sect, cmd_accept, cmd_reject;
	logic data_unsure, busy_progress_bit, ctrl_ready, suspend_flag;
	logic [3:0] cmd_class;
	logic [5:0] dev_state;
	int error_cnt, samples_checked, tick_cnt;
	fsra_host u_fsra_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_class(cmd_class),
		.cmd_same_sect(cmd_same_sect));
	fsra_core u_fsra_core (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_class(cmd_class),
		.cmd_same_sect(cmd_same_sect), .op_done(op_done), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
		.data_unsure(data_unsure), .busy_progress_bit(busy_progress_bit), .ctrl_ready(ctrl_ready),
		.suspend_flag(suspend_flag), .dev_state(dev_state));
	always #50 sys_clk = ~sys_clk;
	task automatic final_report();
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		tick_cnt++;
		if (tick_cnt == 5000)
		begin
			error_cnt++;
			final_report();
		end
	end
	task automatic ck(input logic ok);
		samples_checked++;
		if (!ok)
		begin
			error_cnt++;
			$display("unexpected at %0t ns: port value differs", $time);
		end
	endtask
	task automatic op(input logic [3:0] c, input logic s, input logic a, input logic [5:0] st);
		u_fsra_host.send(c, s, 0);
		ck(cmd_accept === a && cmd_reject === !a && dev_state === st);
	endtask
	// Runs each class set in acc or rej in class order, expecting accept for acc bits and reject otherwise, with the state kept.
	task automatic tbl(input logic [15:0] acc, input logic [15:0] rej, input logic [5:0] st);
		for (int i = 1; i < 10; i++)
		begin
			if (acc[i] | rej[i])
				op(4'(i), 1'h0, acc[i], st);
		end
	endtask
	task automatic bz(input logic b);
		ck(busy_progress_bit === b && ctrl_ready === !b);
	endtask
	task automatic fin();
		@(posedge sys_clk);
		#1 op_done = 1'h1;
		@(posedge sys_clk);
		#1 op_done = 1'h0;
	endtask
	task automatic t_standby();
		tbl(16'h0086, 16'h0300, 6'h01);
		bz(1'h0);
	endtask
	task automatic t_program();
		op(4'h3, 1'h0, 1'h1, 6'h02);
		bz(1'h1);
		tbl(16'h0002, 16'h02fc, 6'h02);
		op(4'h8, 1'h0, 1'h1, 6'h10);
		ck(suspend_flag === 1'h1 && busy_progress_bit === 1'h1);
		repeat (60) @(posedge sys_clk);
		#1 bz(1'h1);
		repeat (15) @(posedge sys_clk);
		#1 bz(1'h0);
		tbl(16'h0086, 16'h0178, 6'h10);
		u_fsra_host.resume();
		ck(cmd_accept === 1'h1 && dev_state === 6'h02);
		bz(1'h1);
		fin();
		ck(dev_state === 6'h01);
		bz(1'h0);
	endtask
	task automatic t_erase();
		op(4'h4, 1'h0, 1'h1, 6'h04);
		tbl(16'h0002, 16'h02fc, 6'h04);
		op(4'h8, 1'h0, 1'h1, 6'h20);
		repeat (155) @(posedge sys_clk);
		#1 bz(1'h0);
		tbl(16'h0086, 16'h0170, 6'h20);
		op(4'h2, 1'h1, 1'h1, 6'h20);
		ck(data_unsure === 1'h1);
		op(4'h3, 1'h1, 1'h0, 6'h20);
		op(4'h3, 1'h0, 1'h1, 6'h02);
		op(4'h8, 1'h0, 1'h1, 6'h10);
		repeat (80) @(posedge sys_clk);
		op(4'h3, 1'h0, 1'h0, 6'h10);
		op(4'h9, 1'h0, 1'h1, 6'h02);
		fin();
		ck(dev_state === 6'h20 && suspend_flag === 1'h1);
		bz(1'h0);
		op(4'h9, 1'h0, 1'h1, 6'h04);
		bz(1'h1);
		fin();
		ck(dev_state === 6'h01);
	endtask
	task automatic t_subsect();
		op(4'h5, 1'h0, 1'h1, 6'h04);
		op(4'h8, 1'h0, 1'h1, 6'h08);
		repeat (155) @(posedge sys_clk);
		tbl(16'h0086, 16'h0178, 6'h08);
		op(4'h2, 1'h1, 1'h1, 6'h08);
		ck(data_unsure === 1'h1);
		op(4'h9, 1'h0, 1'h1, 6'h04);
		fin();
		ck(dev_state === 6'h01 && suspend_flag === 1'h0);
		u_fsra_host.send(4'h6, 1'h0, 3);
		ck(cmd_accept === 1'h1);
	endtask
	initial
	begin
		sys_clk = 1'h0;
		rst_n = 1'h0;
		op_done = 1'h0;
		repeat (6) @(posedge sys_clk);
		#1 rst_n = 1'h1;
		t_standby();
		t_program();
		t_erase();
		t_subsect();
		final_report();
	end
endmodule
